// *** common/cmam_pkg.sv ***
// Shared constants and types for the core memory address map.
// Assumes a single clock domain; every user names items as cmam_pkg::name.
package cmam_pkg;
    // Program space vectors and sequencing.
    localparam logic [23:0] RESET_VEC = 24'h000000;
    localparam logic [23:0] RESET_TGT = 24'h000002;
    localparam logic [23:0] PRI_IVT   = 24'h000004;
    localparam logic [23:0] ALT_IVT   = 24'h000100;
    localparam logic [23:0] VEC_END   = 24'h000200;
    localparam logic [23:0] PC_STEP   = 24'h000002;
    localparam logic [6:0]  VEC_LAST  = 7'h7D;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    // Data space layout.
    localparam int          PSV_BIT   = 15;
    localparam logic [15:0] WREG_END  = 16'h0020;
    localparam logic [15:0] SFR_END   = 16'h0800;
    localparam logic [15:0] NEAR_END  = 16'h2000;
    localparam logic [15:0] RAM_BASE  = 16'h0800;
    localparam int          RAM_BYTES = 30720;
    localparam logic [15:0] Y_BASE    = 16'h4000;
    localparam logic [15:0] W15_RST   = 16'h0800;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [1:0]  BE_LO     = 2'h1;
    localparam logic [1:0]  BE_HI     = 2'h2;
    localparam logic [1:0]  BE_WORD   = 2'h3;

    typedef enum logic [1:0] {
        MODE_NEAR = 2'h0,
        MODE_ABS  = 2'h1,
        MODE_PINC = 2'h2,
        MODE_PDEC = 2'h3
    } cmam_mode_e;

    typedef enum logic [4:0] {
        RG_WREG  = 5'h01,
        RG_SFR   = 5'h02,
        RG_RAM   = 5'h04,
        RG_EMPTY = 5'h08,
        RG_PSV   = 5'h10
    } cmam_region_e;
endpackage : cmam_pkg

// *** common/cmam_ram_if.sv ***
// Carrier between the address map and its data RAM: two reads, one write.
// Assumes word indices are already range checked by the controller.
`timescale 1ns/100ps
interface cmam_ram_if #(parameter int AW = 14);
    logic          x_en;
    logic [AW-1:0] x_idx;
    logic [15:0]   x_data;
    logic          y_en;
    logic [AW-1:0] y_idx;
    logic [15:0]   y_data;
    logic          w_en;
    logic [1:0]    w_be;
    logic [AW-1:0] w_idx;
    logic [15:0]   w_data;

    modport ctl (output x_en, x_idx, y_en, y_idx, w_en, w_be, w_idx, w_data,
                 input  x_data, y_data);
    modport mem (input  x_en, x_idx, y_en, y_idx, w_en, w_be, w_idx, w_data,
                 output x_data, y_data);
endinterface : cmam_ram_if

// *** design/cmam_dpram.sv ***
// Data RAM with X and Y read ports and one byte-laned write port.
// Assumes the controller never reads and writes one word in a cycle.
`timescale 1ns/100ps
module cmam_dpram #(
    parameter int DEPTH = 15360,
    parameter int AW    = 14
) (
    input  logic   clk_sys,
    cmam_ram_if.mem ram
);
    logic [7:0] lo_mem [DEPTH];
    logic [7:0] hi_mem [DEPTH];

    if (DEPTH < 2 || (1 << AW) < DEPTH) begin : g_chk
        $error("cmam_dpram: depth does not fit the index width");
    end

    // Two byte-wide arrays share one decode but have their own write lines.
    always_ff @(posedge clk_sys) begin
        if (ram.w_en && ram.w_be[0]) begin
            lo_mem[ram.w_idx] <= ram.w_data[7:0];
        end
        if (ram.w_en && ram.w_be[1]) begin
            hi_mem[ram.w_idx] <= ram.w_data[15:8];
        end
    end

    // Both read paths answer one cycle later from a register.
    always_ff @(posedge clk_sys) begin
        if (ram.x_en) begin
            ram.x_data <= {hi_mem[ram.x_idx], lo_mem[ram.x_idx]};
        end
        if (ram.y_en) begin
            ram.y_data <= {hi_mem[ram.y_idx], lo_mem[ram.y_idx]};
        end
    end
endmodule : cmam_dpram

// *** design/cmam_pc.sv ***
// Program counter with reset vector, vector table entry and word split.
// Assumes the core raises at most one of vec_take, pc_jump, pc_advance.
`timescale 1ns/100ps
module cmam_pc (
    input  logic        clk_sys,
    input  logic        resetn,
    input  logic        pc_advance,
    input  logic        pc_reverse,
    input  logic        pc_jump,
    input  logic [23:0] pc_target,
    input  logic        vec_take,
    input  logic        vec_alt,
    input  logic [6:0]  vec_num,
    input  logic [23:0] prog_rdata,
    output logic [23:0] prog_addr,
    output logic [15:0] prog_lo,
    output logic [15:0] prog_hi
);
    logic [23:0] pc_q;
    logic [23:0] vec_addr;

    // Each slot is one program word, two addresses, so the entry is base plus twice the number.
    assign vec_addr = (vec_alt ? cmam_pkg::ALT_IVT : cmam_pkg::PRI_IVT)
                    + {16'h0000, vec_num, 1'b0};
    assign prog_addr = pc_q;

    // Vectors win over jumps; a slot past the table end is ignored.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pc_q <= cmam_pkg::RESET_VEC;
        end else if (vec_take && vec_num <= cmam_pkg::VEC_LAST) begin
            pc_q <= vec_addr;
        end else if (pc_jump) begin
            pc_q <= {pc_target[23:1], 1'b0};
        end else if (pc_advance) begin
            pc_q <= pc_reverse ? pc_q - cmam_pkg::PC_STEP
                               : pc_q + cmam_pkg::PC_STEP;
        end
    end

    // Lower word at the even address, upper word at the odd one.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prog_lo <= 16'h0000;
            prog_hi <= 16'h0000;
        end else begin
            prog_lo <= prog_rdata[15:0];
            prog_hi <= {cmam_pkg::BYTE_ZERO, prog_rdata[23:16]};
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_pc_even_step: assert property (pc_advance && !pc_jump && !vec_take |=>
        pc_q[0] == 1'b0 && (pc_q == $past(pc_q) + 24'h000002 ||
        pc_q == $past(pc_q) - 24'h000002)) else $error("pc step wrong");
    a_vec_in_table: assert property (vec_take && vec_num <= 7'h7D |=>
        pc_q >= 24'h000004 && pc_q < 24'h000200) else $error("vector out of table");
    a_reset_start: assert property ($rose(resetn) |-> pc_q == 24'h000000)
        else $error("pc not at reset vector");
    c_vec_alt: cover property (vec_take && vec_alt);
endmodule : cmam_pc

// *** design/cmam_top.sv ***
// Data and program address map of the 16-bit core: region decode, byte lanes,
// misaligned-word traps, working registers and the X and Y read paths.
// Assumes the core issues at most one X and one Y access per clk_sys cycle.
// Function
// - Program word is even lower word plus odd upper word, top byte empty.
// - Program counter stays even and moves by two per instruction.
// - Reset starts at address zero; its jump target lives at the next word.
// - Primary vector table follows reset vector; alternate starts at 0x100.
// - Data addresses are 16-bit bytes; top bit selects the program window.
// - Reads outside implemented data memory return zero, word or byte.
// - Low byte sits at the even address, high byte at the odd one.
// - Post-modified pointers move by one for bytes, two for words.
// - Byte reads fetch the word and return the chosen byte on the low lane.
// - Shared word decode with a separate write line per byte lane.
// - Word access at an odd address raises an address error trap.
// - Misaligned read completes, misaligned write is dropped, then trap; a misaligned Y read returns zero.
// - Byte loads into working registers change the low byte only.
// - Sign extension and zero extension of working register low byte.
// - Unused special register addresses below 0x0800 read as zero.
// - Near space below 0x2000 reached through a 13-bit direct field.
// - Whole data space reached by 16-bit direct or pointer addressing.
// - Two address units fetch two words in one instruction.
// - X has separate read and write paths; X read serves unified reads.
// - Y read path serves only the multiply-accumulate class.
// - Modulo addressing in X and Y; bit reversal only on X writes.
// - All writes use unified space; X/Y boundary fixed at build time.
`timescale 1ns/100ps
module cmam_top #(
    parameter int          RAM_BYTES = cmam_pkg::RAM_BYTES,
    parameter logic [15:0] Y_BASE    = cmam_pkg::Y_BASE
) (
    input  logic        clk_sys,
    input  logic        resetn,
    input  logic        pc_advance,
    input  logic        pc_reverse,
    input  logic        pc_jump,
    input  logic [23:0] pc_target,
    input  logic        vec_take,
    input  logic        vec_alt,
    input  logic [6:0]  vec_num,
    input  logic [23:0] prog_rdata,
    output logic [23:0] prog_addr,
    output logic [15:0] prog_lo,
    output logic [15:0] prog_hi,
    input  logic        x_valid,
    input  logic        x_write,
    input  logic        x_byte,
    input  logic [1:0]  x_mode,
    input  logic [12:0] x_near,
    input  logic [15:0] x_abs,
    input  logic [3:0]  x_ptr,
    input  logic [15:0] x_wdata,
    input  logic        x_modulo,
    input  logic        x_bitrev,
    output logic        x_rvalid,
    output logic [15:0] x_rdata,
    input  logic        y_valid,
    input  logic        y_mac,
    input  logic        y_dec,
    input  logic        y_modulo,
    input  logic [3:0]  y_ptr,
    output logic        y_rvalid,
    output logic [15:0] y_rdata,
    input  logic [15:0] mod_start,
    input  logic [15:0] mod_end,
    input  logic [15:0] bitrev_step,
    output logic        addr_err_trap,
    output logic        sfr_rd,
    output logic        sfr_wr,
    output logic [10:0] sfr_addr,
    output logic [1:0]  sfr_be,
    output logic [15:0] sfr_wdata,
    input  logic        sfr_hit,
    input  logic [15:0] sfr_rdata,
    output logic        psv_rd,
    output logic [14:0] psv_addr,
    input  logic [15:0] psv_rdata,
    input  logic        wl_valid,
    input  logic        wl_byte,
    input  logic [3:0]  wl_sel,
    input  logic [15:0] wl_data,
    input  logic        ext_valid,
    input  logic        ext_sign,
    input  logic [3:0]  ext_sel
);
    localparam int          DEPTH   = RAM_BYTES / 2;
    localparam int          AW      = $clog2(DEPTH);
    localparam logic [15:0] RAM_END = 16'(int'(cmam_pkg::RAM_BASE) + RAM_BYTES);

    // The X/Y split is a build constant, so software can never move it.
    if (RAM_BYTES < 4 || RAM_BYTES % 2 != 0 || RAM_BYTES > 30720 ||
        Y_BASE <= cmam_pkg::RAM_BASE || Y_BASE >= RAM_END || Y_BASE[0]) begin : g_chk
        $error("cmam_top: RAM size or X/Y boundary not supported");
    end

    cmam_ram_if #(.AW(AW)) ram ();

    cmam_dpram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
        .clk_sys (clk_sys),
        .ram     (ram.mem)
    );

    cmam_pc u_pc (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .pc_advance (pc_advance),
        .pc_reverse (pc_reverse),
        .pc_jump    (pc_jump),
        .pc_target  (pc_target),
        .vec_take   (vec_take),
        .vec_alt    (vec_alt),
        .vec_num    (vec_num),
        .prog_rdata (prog_rdata),
        .prog_addr  (prog_addr),
        .prog_lo    (prog_lo),
        .prog_hi    (prog_hi)
    );

    // Region of a byte address; upper half always goes to the program window.
    function automatic cmam_pkg::cmam_region_e region(input logic [15:0] ea);
        if (ea[cmam_pkg::PSV_BIT])    return cmam_pkg::RG_PSV;
        if (ea < cmam_pkg::WREG_END)  return cmam_pkg::RG_WREG;
        if (ea < cmam_pkg::SFR_END)   return cmam_pkg::RG_SFR;
        if (ea < RAM_END)             return cmam_pkg::RG_RAM;
        return cmam_pkg::RG_EMPTY;
    endfunction : region

    function automatic logic [AW-1:0] widx(input logic [15:0] ea);
        logic [15:0] off;
        off = ea - cmam_pkg::RAM_BASE;
        return off[AW:1];
    endfunction : widx

    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction : rev16

    // Pointer update: linear, modulo wrap, or reverse-carry for X writes.
    function automatic logic [15:0] post_mod(input logic [15:0] p, input logic [15:0] st,
                                             input logic dec, input logic md,
                                             input logic br);
        logic [15:0] n;
        logic [15:0] len;
        len = mod_end - mod_start + 16'h0001;
        if (br)       n = rev16(rev16(p) + rev16(bitrev_step));
        else if (dec) n = p - st;
        else          n = p + st;
        if (md && !br && !dec && n > mod_end)   n = n - len;
        if (md && !br && dec && n < mod_start)  n = n + len;
        return n;
    endfunction : post_mod

    logic [15:0] wreg_q [16];
    logic [15:0] x_ea;
    logic [15:0] y_ea;
    logic [15:0] x_step;
    logic [15:0] x_ptr_d;
    logic [15:0] y_ptr_d;
    logic [15:0] x_lanes;
    logic [1:0]  x_be;
    logic        x_ind;
    logic        x_mis;
    logic        x_wr_ok;
    logic        y_go;
    logic        y_ok;
    logic        y_mis;
    cmam_pkg::cmam_region_e x_rg;

    // X address: 13-bit near field, 16-bit direct field or a pointer.
    always_comb begin
        unique case (cmam_pkg::cmam_mode_e'(x_mode))
            cmam_pkg::MODE_NEAR: x_ea = {3'h0, x_near};
            cmam_pkg::MODE_ABS:  x_ea = x_abs;
            cmam_pkg::MODE_PINC,
            cmam_pkg::MODE_PDEC: x_ea = wreg_q[x_ptr];
        endcase
    end

    assign x_rg    = region(x_ea);
    assign x_ind   = x_mode[1];
    assign x_step  = x_byte ? cmam_pkg::STEP_BYTE : cmam_pkg::STEP_WORD;
    always_comb x_ptr_d = post_mod(x_ea, x_step, x_mode == cmam_pkg::MODE_PDEC, x_modulo,
                                   x_write && x_bitrev && x_mode == cmam_pkg::MODE_PINC);
    // The check uses only size and bit zero, so it settles before any write line.
    assign x_mis   = x_valid && !x_byte && x_ea[0];
    assign x_wr_ok = x_valid && x_write && !x_mis;
    assign x_be    = !x_byte ? cmam_pkg::BE_WORD :
                     x_ea[0] ? cmam_pkg::BE_HI : cmam_pkg::BE_LO;
    assign x_lanes = x_byte ? {x_wdata[7:0], x_wdata[7:0]} : x_wdata;

    // Y path: pointer only, word reads, Y half of RAM, MAC class only.
    assign y_ea    = wreg_q[y_ptr];
    assign y_go    = y_valid && y_mac;
    assign y_mis   = y_go && y_ea[0];
    assign y_ok    = y_go && !y_ea[0] && y_ea >= Y_BASE && y_ea < RAM_END;
    always_comb y_ptr_d = post_mod(y_ea, cmam_pkg::STEP_WORD, y_dec, y_modulo, 1'b0);

    // RAM strobes; every write enters through the unified X write path.
    assign ram.x_en   = x_valid && !x_write && x_rg == cmam_pkg::RG_RAM;
    assign ram.x_idx  = widx(x_ea);
    assign ram.y_en   = y_ok;
    assign ram.y_idx  = widx(y_ea);
    assign ram.w_en   = x_wr_ok && x_rg == cmam_pkg::RG_RAM;
    assign ram.w_be   = x_be;
    assign ram.w_idx  = widx(x_ea);
    assign ram.w_data = x_lanes;

    // Special registers and the program window are served outside this block.
    assign sfr_rd    = x_valid && !x_write && x_rg == cmam_pkg::RG_SFR;
    assign sfr_wr    = x_wr_ok && x_rg == cmam_pkg::RG_SFR;
    assign sfr_addr  = x_ea[10:0];
    assign sfr_be    = x_be;
    assign sfr_wdata = x_lanes;
    assign psv_rd    = x_valid && !x_write && x_rg == cmam_pkg::RG_PSV;
    assign psv_addr  = x_ea[14:0];

    logic        x_rv_q;
    logic        x_ram_q;
    logic        x_hi_q;
    logic        x_byte_q;
    logic [15:0] x_imm_q;
    logic        y_rv_q;
    logic        y_ok_q;
    logic        trap_q;
    logic [15:0] x_word;

    // Read stage: non-RAM data is captured now, RAM data arrives next cycle.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            x_rv_q   <= 1'b0;
            x_ram_q  <= 1'b0;
            x_hi_q   <= 1'b0;
            x_byte_q <= 1'b0;
            x_imm_q  <= 16'h0000;
        end else begin
            x_rv_q   <= x_valid && !x_write;
            x_ram_q  <= x_rg == cmam_pkg::RG_RAM;
            x_hi_q   <= x_ea[0];
            x_byte_q <= x_byte;
            unique case (x_rg)
                cmam_pkg::RG_WREG: x_imm_q <= wreg_q[x_ea[4:1]];
                cmam_pkg::RG_SFR:  x_imm_q <= sfr_hit ? sfr_rdata : 16'h0000;
                cmam_pkg::RG_PSV:  x_imm_q <= psv_rdata;
                default:           x_imm_q <= 16'h0000;
            endcase
        end
    end

    // Trap flags one cycle after the offending access, as the instruction ends.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            trap_q <= 1'b0;
            y_rv_q <= 1'b0;
            y_ok_q <= 1'b0;
        end else begin
            trap_q <= x_mis || y_mis;
            y_rv_q <= y_go;
            y_ok_q <= y_ok;
        end
    end

    // Byte reads take the whole word and move the chosen byte to the low lane.
    assign x_word        = x_ram_q ? ram.x_data : x_imm_q;
    assign x_rdata       = !x_byte_q ? x_word :
                           {cmam_pkg::BYTE_ZERO, x_hi_q ? x_word[15:8] : x_word[7:0]};
    assign x_rvalid      = x_rv_q;
    assign y_rdata       = y_ok_q ? ram.y_data : 16'h0000;
    assign y_rvalid      = y_rv_q;
    assign addr_err_trap = trap_q;

    // Working registers; later statements win: extend, load, data write, X, Y.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 15; i++) begin
                wreg_q[i] <= 16'h0000;
            end
            wreg_q[15] <= cmam_pkg::W15_RST;
        end else begin
            if (y_go && !y_mis) begin
                wreg_q[y_ptr] <= y_ptr_d;
            end
            if (x_valid && x_ind) begin
                wreg_q[x_ptr] <= x_ptr_d;
            end
            if (x_wr_ok && x_rg == cmam_pkg::RG_WREG && x_be[0]) begin
                wreg_q[x_ea[4:1]][7:0] <= x_lanes[7:0];
            end
            if (x_wr_ok && x_rg == cmam_pkg::RG_WREG && x_be[1]) begin
                wreg_q[x_ea[4:1]][15:8] <= x_lanes[15:8];
            end
            if (wl_valid && wl_byte) begin
                wreg_q[wl_sel][7:0] <= wl_data[7:0];
            end else if (wl_valid) begin
                wreg_q[wl_sel] <= wl_data;
            end
            if (ext_valid) begin
                wreg_q[ext_sel][15:8] <= ext_sign ? {8{wreg_q[ext_sel][7]}}
                                                  : cmam_pkg::BYTE_ZERO;
            end
        end
    end

    // Helper values that only the checks below read.
    logic [7:0]  wl_hi_now;
    logic [7:0]  ext_lo_now;
    assign wl_hi_now  = wreg_q[wl_sel][15:8];
    assign ext_lo_now = wreg_q[ext_sel][7:0];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_misalign_trap: assert property (x_valid && !x_byte && x_ea[0] |=> addr_err_trap)
        else $error("odd word access without trap");
    a_misalign_nowr: assert property (x_mis && x_write |-> !ram.w_en && !sfr_wr)
        else $error("misaligned write reached storage");
    a_empty_zero: assert property (x_valid && !x_write && x_rg == cmam_pkg::RG_EMPTY
        |=> x_rvalid && x_rdata == 16'h0000) else $error("empty read not zero");
    a_byte_lane_rd: assert property (x_valid && !x_write && x_byte |=>
        x_rdata[15:8] == 8'h00) else $error("byte read upper lane set");
    a_byte_lane_we: assert property (ram.w_en && x_byte |-> ram.w_be ==
        (x_ea[0] ? 2'h2 : 2'h1)) else $error("wrong byte lane write");
    a_ptr_step: assert property (x_valid && x_mode == 2'h2 && !x_modulo && !x_bitrev
        && !wl_valid && !ext_valid && x_rg != cmam_pkg::RG_WREG |=>
        wreg_q[$past(x_ptr)] == $past(x_ea) + ($past(x_byte) ? 16'h0001 : 16'h0002))
        else $error("pointer step wrong");
    a_wload_keep_hi: assert property (wl_valid && wl_byte && !ext_valid |=>
        wreg_q[$past(wl_sel)][15:8] == $past(wl_hi_now))
        else $error("byte load changed high byte");
    a_ext_sign: assert property (ext_valid && ext_sign && !wl_valid |=>
        wreg_q[$past(ext_sel)] == {{8{$past(ext_lo_now[7])}}, $past(ext_lo_now)})
        else $error("sign extension wrong");
    a_y_mac_only: assert property (y_valid && !y_mac |-> !ram.y_en ##1 !y_rvalid)
        else $error("Y path used outside MAC class");
    a_sfr_unused: assert property (sfr_rd && !sfr_hit |=> x_rdata == 16'h0000)
        else $error("unused special register not zero");
    a_near_range: assert property (x_valid && x_mode == 2'h0 |->
        x_ea < cmam_pkg::NEAR_END) else $error("near address out of range");
    a_psv_route: assert property (x_valid && x_ea[15] |-> !ram.x_en && !sfr_rd &&
        psv_rd == !x_write) else $error("program window misrouted");

    c_dual_fetch: cover property (ram.x_en && ram.y_en);
    c_misalign_rd: cover property (x_mis && !x_write);
    c_byte_hi_wr: cover property (ram.w_en && x_byte && x_ea[0]);
endmodule : cmam_top

// *** testbench/cmam_far_model.sv ***
// Far-side model: program memory words, one peripheral register, program window.
// Assumes the address map drives its read strobes and addresses combinationally.
`timescale 1ns/100ps
module cmam_far_model (
    input  logic [23:0] prog_addr,
    output logic [23:0] prog_rdata,
    input  logic        sfr_rd,
    input  logic [10:0] sfr_addr,
    output logic        sfr_hit,
    output logic [15:0] sfr_rdata,
    input  logic        psv_rd,
    output logic [15:0] psv_rdata
);
    // Unselected buses show a non-zero pattern so a stale zero cannot pass.
    assign prog_rdata = {8'h5A, prog_addr[15:0]};
    assign sfr_hit    = sfr_rd && (sfr_addr == 11'h020);
    assign sfr_rdata  = sfr_hit ? 16'hC3A5 : 16'hFFFF;
    assign psv_rdata  = psv_rd ? 16'h5AC3 : 16'hA53C;
endmodule : cmam_far_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the address map: table of X accesses, then hand tests.
// Assumes the far-side model answers peripheral and program window reads.
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {logic w; logic b; logic [1:0] m; logic [15:0] a, d, e; logic t;} cmam_row_s;
    logic        clk_sys, resetn, pc_advance, pc_reverse, pc_jump, vec_take, vec_alt, tr;
    logic        x_valid, x_write, x_byte, x_modulo, x_bitrev, x_rvalid, y_valid, y_mac;
    logic        y_dec, y_modulo, y_rvalid, addr_err_trap, sfr_rd, sfr_wr, sfr_hit, psv_rd;
    logic        wl_valid, wl_byte, ext_valid, ext_sign;
    logic [23:0] pc_target, prog_rdata, prog_addr;
    logic [15:0] prog_lo, prog_hi, x_abs, x_wdata, x_rdata, y_rdata, mod_start, mod_end, rd;
    logic [15:0] bitrev_step, sfr_wdata, sfr_rdata, psv_rdata, wl_data;
    logic [12:0] x_near;
    logic [10:0] sfr_addr;
    logic [14:0] psv_addr;
    logic [6:0]  vec_num;
    logic [3:0]  x_ptr, y_ptr, wl_sel, ext_sel;
    logic [1:0]  x_mode, sfr_be;
    int          errors, cmp_count, cyc;
    // Small RAM keeps an empty zone below the program window.
    cmam_row_s rows [20] = '{
        '{1,0,1,16'h0800,16'h1234,16'hDEAD,0}, '{0,0,1,16'h0800,0,16'h1234,0},
        '{0,1,1,16'h0801,0,16'h0012,0}, '{1,1,0,16'h0801,16'h00AB,16'hDEAD,0},
        '{0,0,1,16'h0800,0,16'hAB34,0}, '{1,0,1,16'h0802,16'h1111,16'hDEAD,0},
        '{1,0,1,16'h0803,16'h5555,16'hDEAD,1}, '{0,0,1,16'h0803,0,16'h1111,1},
        '{0,0,1,16'h1800,0,16'h0000,0}, '{0,1,1,16'h1801,0,16'h0000,0},
        '{0,0,1,16'h0100,0,16'h0000,0}, '{0,0,1,16'h0020,0,16'hC3A5,0},
        '{0,0,1,16'h8002,0,16'h5AC3,0}, '{1,0,1,16'h0006,16'h0800,16'hDEAD,0},
        '{0,0,2,16'h0000,0,16'hAB34,0}, '{0,1,2,16'h0000,0,16'h0011,0},
        '{0,0,1,16'h0006,0,16'h0803,0}, '{1,0,1,16'h1000,16'h4321,16'hDEAD,0},
        '{1,0,1,16'h0008,16'h1000,16'hDEAD,0}, '{1,0,1,16'h0004,16'h80F0,16'hDEAD,0}};
    logic [4:0]  pc_ctl [7] = '{5'h10, 5'h10, 5'h18, 5'h04, 5'h02, 5'h03, 5'h03};
    logic [23:0] pc_exp [7] = '{24'h2, 24'h4, 24'h2, 24'h122, 24'hA, 24'h106, 24'h106};
    logic [15:0] w_exp [4]  = '{16'h8085, 16'hFF85, 16'h0085, 16'h3385};
    assign x_near = x_abs[12:0];
    cmam_top #(.RAM_BYTES(4096), .Y_BASE(16'h1000)) DUT (.*);
    cmam_far_model u_far (.*);
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    // One X access; the answer and any trap are looked for over two cycles.
    task xacc(input logic w, input logic b, input logic [1:0] m, input logic [15:0] a,
              input logic [15:0] d, output logic [15:0] r, output logic t);
        {x_write, x_byte, x_mode, x_abs, x_wdata, x_valid} = {w, b, m, a, d, 1'b1};
        @(negedge clk_sys);
        x_valid = 1'b0;
        r = 16'hDEAD;
        t = 1'b0;
        repeat (2) begin
            if (x_rvalid === 1'b1) r = x_rdata;
            t |= (addr_err_trap === 1'b1);
            @(negedge clk_sys);
        end
    endtask : xacc
    task print_verdict;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    // Free-running 125 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Hang guard: the whole run needs under 120 cycles.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            print_verdict();
        end
    end
    // Main sequence: reset, X table, Y path, register loads, program counter.
    initial begin
        {pc_advance, pc_reverse, pc_jump, vec_take, vec_alt, x_valid, x_write, x_byte} = '0;
        {x_modulo, x_bitrev, y_valid, y_mac, y_dec, y_modulo, wl_valid, ext_valid} = '0;
        {pc_target, x_abs, x_wdata, mod_start, mod_end, bitrev_step} = {24'h123, 80'h0};
        {vec_num, x_mode, wl_byte, wl_data, ext_sign} = {7'h3, 2'h0, 1'b1, 16'h3385, 1'b0};
        {x_ptr, y_ptr, wl_sel, ext_sel, resetn} = {4'h3, 4'h4, 4'h2, 4'h2, 1'b0};
        repeat (3) @(negedge clk_sys);
        resetn = 1'b1;
        chk(prog_addr, 24'h0);
        foreach (rows[i]) begin
            xacc(rows[i].w, rows[i].b, rows[i].m, rows[i].a, rows[i].d, rd, tr);
            chk(rd, rows[i].e);
            chk(tr, rows[i].t);
        end
        y_dec = 1'b1;
        for (int k = 0; k < 2; k++) begin
            {y_mac, y_valid} = {k[0], 1'b1};
            @(negedge clk_sys);
            y_valid = 1'b0;
            chk(y_rvalid, k[0]);
            chk(y_rdata, k[0] ? 16'h4321 : 16'h0000);
            @(negedge clk_sys);
        end
        xacc(1'b0, 1'b0, 2'h1, 16'h0008, 16'h0, rd, tr);
        chk(rd, 16'h0FFE);
        for (int k = 0; k < 4; k++) begin
            {wl_valid, wl_byte, ext_valid, ext_sign} = {k[0] == k[1], k != 3, k[0] != k[1], k == 1};
            @(negedge clk_sys);
            {wl_valid, ext_valid} = 2'b00;
            xacc(1'b0, 1'b0, 2'h1, 16'h0004, 16'h0, rd, tr);
            chk(rd, w_exp[k]);
        end
        // Modulo wrap on a byte step, then a reverse-carry step on an X write.
        {x_modulo, mod_start, mod_end, bitrev_step} = {1'b1, 16'h0800, 16'h0803, 16'h0008};
        xacc(1'b0, 1'b1, 2'h2, 16'h0, 16'h0, rd, tr);
        chk(rd, 16'h0011);
        xacc(1'b0, 1'b0, 2'h1, 16'h0006, 16'h0, rd, tr);
        chk(rd, 16'h0800);
        x_bitrev = 1'b1;
        xacc(1'b1, 1'b0, 2'h2, 16'h0, 16'hBEEF, rd, tr);
        xacc(1'b0, 1'b0, 2'h1, 16'h0006, 16'h0, rd, tr);
        chk(rd, 16'h0808);
        {x_modulo, x_bitrev} = 2'b00;
        // Strobes to the special registers and the program window settle in the request cycle.
        {x_write, x_byte, x_mode, x_abs, x_wdata, x_valid} = {2'b11, 2'h1, 16'h0021, 16'h00C3, 1'b1};
        #1 chk({sfr_wr, sfr_be, sfr_addr, sfr_wdata}, {1'b1, 2'h2, 11'h021, 16'hC3C3});
        @(negedge clk_sys);
        {x_write, x_byte, x_abs} = {2'b00, 16'h8002};
        #1 chk({psv_rd, psv_addr}, {1'b1, 15'h0002});
        @(negedge clk_sys);
        x_valid = 1'b0;
        @(negedge clk_sys);
        for (int k = 0; k < 7; k++) begin
            {pc_advance, pc_reverse, pc_jump, vec_take, vec_alt} = pc_ctl[k];
            vec_num = (k == 6) ? 7'h7E : 7'h03;
            @(negedge clk_sys);
            {pc_advance, pc_jump, vec_take} = 3'b000;
            chk(prog_addr, pc_exp[k]);
        end
        @(negedge clk_sys);
        chk({prog_hi, prog_lo}, 32'h005A_0106);
        // A second reset in mid-run must bring back the start state.
        resetn = 1'b0;
        @(negedge clk_sys);
        chk({prog_addr, x_rvalid, addr_err_trap}, 26'h0);
        resetn = 1'b1;
        xacc(1'b0, 1'b0, 2'h1, 16'h001E, 16'h0, rd, tr);
        chk(rd, 16'h0800);
        print_verdict();
    end
endmodule : tb_top
